/* File: hw/mtmc_pkg.sv */
// Package for the five-channel timer mode control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
`default_nettype none
package mtmc_pkg;
  localparam int unsigned NUM_CH = 5;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] START_OFS = 8'h00;
  localparam logic [7:0] SYNC_OFS = 8'h04;
  localparam logic [7:0] MODE_OFS = 8'h08;
  localparam logic [7:0] CH_BASE_OFS = 8'h10;
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] CTRL_SUB = 4'h0;
  localparam logic [3:0] COUNT_SUB = 4'h4;
  localparam logic [3:0] GEN_A_SUB = 4'h8;
  localparam logic [3:0] GEN_B_SUB = 4'hC;
  // Field positions
  localparam int unsigned PHASE_BIT = 2;
  localparam int unsigned COMBO_LSB = 4;
  localparam int unsigned CTRL_FIXED_BIT = 7;
  localparam int unsigned PHASE_CH = 2;
  localparam int unsigned COMBO_CH_LO = 3;
  localparam int unsigned COMBO_CH_HI = 4;
  // Reset values
  localparam logic [4:0] START_RST = 5'h00;
  localparam logic [4:0] SYNC_RST = 5'h00;
  localparam logic PHASE_RST = 1'h0;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  // Prescaler and clear codes
  localparam logic [2:0] PSC_EXT_A = 3'h4;
  localparam logic [2:0] PSC_EXT_B = 3'h5;
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;
  typedef enum logic [1:0] {
    MTMC_COMBO_NORM0 = 2'b00,
    MTMC_COMBO_NORM1 = 2'b01,
    MTMC_COMBO_CPWM = 2'b10,
    MTMC_COMBO_RSPWM = 2'b11
  } mtmc_combo_t;
  typedef struct packed {
    logic [1:0] clear_source;
    logic [1:0] edge_select;
    logic [2:0] prescale_select;
  } mtmc_ctrl_t;
  localparam mtmc_ctrl_t CTRL_RST = 7'h00;
endpackage : mtmc_pkg
`default_nettype wire

/* File: hw/mtmc_timer.sv */
// Five-channel 16-bit timer: clock source, clear source, sync, phase and combination modes.
// Assumes an Avalon-MM master on sys_clk_i; external clock pins are asynchronous.
//
// Implementation choices: the Avalon-MM slave port and the address map.
`default_nettype none
module mtmc_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Avalon-MM slave
  input wire logic [mtmc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // External clock pins
  input wire logic external_clock_input_a_i,
  input wire logic external_clock_input_b_i,
  // PWM pair from channel 3 count against its general register B
  output logic [1:0] pwm_o
);
  localparam int N = mtmc_pkg::NUM_CH;

  logic [4:0] start, next_start, sync, next_sync;
  logic phase, next_phase;
  mtmc_pkg::mtmc_combo_t combo, next_combo;
  mtmc_pkg::mtmc_ctrl_t ctrl [N];
  mtmc_pkg::mtmc_ctrl_t next_ctrl [N];
  logic [15:0] timer_count_value [N];
  logic [15:0] next_count [N];
  logic [15:0] general_register_a [N];
  logic [15:0] next_gen_a [N];
  logic [15:0] general_register_b [N];
  logic [15:0] next_gen_b [N];
  logic tri_down, next_tri_down;
  logic [2:0] div, next_div;
  logic [1:0] a_sync, b_sync, next_a_sync, next_b_sync;
  logic a_old, b_old, next_a_old, next_b_old;
  logic wait_q, next_wait;
  logic [31:0] rdata, next_rdata;
  logic [1:0] pwm, next_pwm;

  // Picks the divided internal tick or the external edge for a prescaler code
  function automatic logic clk_tick(input logic [2:0] psc, input logic [2:0] d,
                                    input logic ea, input logic eb);
    case (psc)
      3'h0: clk_tick = 1'b1;
      3'h1: clk_tick = d[0];
      3'h2: clk_tick = &d[1:0];
      3'h3: clk_tick = &d;
      mtmc_pkg::PSC_EXT_A: clk_tick = ea;
      mtmc_pkg::PSC_EXT_B: clk_tick = eb;
      default: clk_tick = 1'b0;
    endcase
  endfunction

  // Rising, falling or both edges of an external pin
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
  endfunction

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb begin
    logic a_rise, a_fall, b_rise, b_fall;
    logic [N-1:0] tick, own_clr, clr;
    logic sync_clr, req, wr_fire, q_up, q_dn, wr_sync_cnt;
    logic [15:0] wr_cnt_val;
    logic [7:0] ofs;
    logic [3:0] sub;
    logic [2:0] ch;
    logic ch_hit;
    a_rise = 1'b0;
    a_fall = 1'b0;
    b_rise = 1'b0;
    b_fall = 1'b0;
    tick = '0;
    own_clr = '0;
    clr = '0;
    sync_clr = 1'b0;
    req = avs_read_i | avs_write_i;
    wr_fire = avs_write_i & ~wait_q;
    q_up = 1'b0;
    q_dn = 1'b0;
    wr_sync_cnt = 1'b0;
    wr_cnt_val = avs_writedata_i[15:0];
    ofs = avs_address_i - mtmc_pkg::CH_BASE_OFS;
    sub = ofs[3:0];
    ch = ofs[6:4];
    ch_hit = (avs_address_i >= mtmc_pkg::CH_BASE_OFS) && (ofs[7] == 1'b0) && (ch < 3'(N));
    next_start = start;
    next_sync = sync;
    next_phase = phase;
    next_combo = combo;
    next_ctrl = ctrl;
    next_count = timer_count_value;
    next_gen_a = general_register_a;
    next_gen_b = general_register_b;
    next_tri_down = tri_down;
    next_rdata = rdata;
    // Pins go through two flops before any edge logic looks at them
    next_a_sync = {a_sync[0], external_clock_input_a_i};
    next_b_sync = {b_sync[0], external_clock_input_b_i};
    next_a_old = a_sync[1];
    next_b_old = b_sync[1];
    a_rise = a_sync[1] & ~a_old;
    a_fall = ~a_sync[1] & a_old;
    b_rise = b_sync[1] & ~b_old;
    b_fall = ~b_sync[1] & b_old;
    next_div = div + 3'h1;
    for (int c = 0; c < N; c++) begin
      tick[c] = start[c] & clk_tick(ctrl[c].prescale_select, div,
                                    edge_hit(ctrl[c].edge_select, a_rise, a_fall),
                                    edge_hit(ctrl[c].edge_select, b_rise, b_fall));
    end
    // quadrature decode on pins A and B
    if (phase) begin
      q_up = (a_sync[1] ^ b_old) & (a_rise | a_fall | b_rise | b_fall);
      q_dn = (a_old ^ b_sync[1]) & (a_rise | a_fall | b_rise | b_fall);
      tick[mtmc_pkg::PHASE_CH] = start[mtmc_pkg::PHASE_CH] & (q_up ^ q_dn);
    end
    for (int c = 0; c < N; c++) begin
      own_clr[c] = tick[c] &
        (((ctrl[c].clear_source == mtmc_pkg::CLR_MATCH_A) &&
          (timer_count_value[c] == general_register_a[c])) ||
         ((ctrl[c].clear_source == mtmc_pkg::CLR_MATCH_B) &&
          (timer_count_value[c] == general_register_b[c])));
    end
    sync_clr = |(own_clr & sync);
    for (int c = 0; c < N; c++) begin
      clr[c] = own_clr[c] | ((ctrl[c].clear_source == mtmc_pkg::CLR_SYNC) & sync[c] & sync_clr);
      if (clr[c]) begin
        next_count[c] = 16'h0000;
      end else if (tick[c]) begin
        if ((c == mtmc_pkg::PHASE_CH) && phase && q_dn) begin
          next_count[c] = timer_count_value[c] - 16'h0001;
        end else begin
          next_count[c] = timer_count_value[c] + 16'h0001;
        end
      end
    end
    // independent channels need no override here
    case (combo)
      mtmc_pkg::MTMC_COMBO_CPWM: begin
        // triangle on channel 3, channel 4 locked to it
        if (tick[mtmc_pkg::COMBO_CH_LO]) begin
          if (!tri_down && (timer_count_value[3] >= general_register_a[3])) begin
            next_tri_down = 1'b1;
            next_count[3] = timer_count_value[3] - 16'h0001;
          end else if (tri_down && (timer_count_value[3] == 16'h0000)) begin
            next_tri_down = 1'b0;
            next_count[3] = 16'h0001;
          end else begin
            next_count[3] = tri_down ? timer_count_value[3] - 16'h0001 :
                                       timer_count_value[3] + 16'h0001;
          end
        end else begin
          next_count[3] = timer_count_value[3];
        end
        next_count[4] = next_count[3];
      end
      mtmc_pkg::MTMC_COMBO_RSPWM: begin
        // sawtooth reset on channel 3 general A
        next_tri_down = 1'b0;
        if (tick[mtmc_pkg::COMBO_CH_LO]) begin
          next_count[3] = (timer_count_value[3] == general_register_a[3]) ? 16'h0000 :
                          timer_count_value[3] + 16'h0001;
        end else begin
          next_count[3] = timer_count_value[3];
        end
        next_count[4] = next_count[3];
      end
      default: begin
        next_tri_down = 1'b0;
      end
    endcase
    // Complementary pair; a dead band would need its own register
    next_pwm[0] = (combo[1]) & (next_count[3] < general_register_b[3]);
    next_pwm[1] = (combo[1]) & ~(next_count[3] < general_register_b[3]);
    // Bus: one wait cycle, then a single-cycle answer
    next_wait = ~(req & wait_q);
    if (avs_read_i && wait_q) begin
      if (avs_address_i == mtmc_pkg::START_OFS) begin
        next_rdata = {27'h0, start};
      end else if (avs_address_i == mtmc_pkg::SYNC_OFS) begin
        next_rdata = {27'h0, sync};
      end else if (avs_address_i == mtmc_pkg::MODE_OFS) begin
        next_rdata = {26'h0, combo, 1'b0, phase, 2'h0};
      end else if (ch_hit && (sub == mtmc_pkg::CTRL_SUB)) begin
        next_rdata = {24'h0, 1'b1, ctrl[ch]};
      end else if (ch_hit && (sub == mtmc_pkg::COUNT_SUB)) begin
        next_rdata = {16'h0, timer_count_value[ch]};
      end else if (ch_hit && (sub == mtmc_pkg::GEN_A_SUB)) begin
        next_rdata = {16'h0, general_register_a[ch]};
      end else if (ch_hit && (sub == mtmc_pkg::GEN_B_SUB)) begin
        next_rdata = {16'h0, general_register_b[ch]};
      end else begin
        next_rdata = 32'h0;
      end
    end
    if (wr_fire && avs_byteenable_i[0]) begin
      if (avs_address_i == mtmc_pkg::START_OFS) begin
        next_start = avs_writedata_i[4:0];
      end else if (avs_address_i == mtmc_pkg::SYNC_OFS) begin
        next_sync = avs_writedata_i[4:0];
      end else if (avs_address_i == mtmc_pkg::MODE_OFS) begin
        next_phase = avs_writedata_i[mtmc_pkg::PHASE_BIT];
        next_combo = mtmc_pkg::mtmc_combo_t'(avs_writedata_i[mtmc_pkg::COMBO_LSB +: 2]);
      end else if (ch_hit && (sub == mtmc_pkg::CTRL_SUB)) begin
        next_ctrl[ch] = avs_writedata_i[6:0];
      end
    end
    if (wr_fire && ch_hit) begin
      if (sub == mtmc_pkg::COUNT_SUB) begin
        wr_cnt_val = merge16(timer_count_value[ch], avs_writedata_i, avs_byteenable_i);
        next_count[ch] = wr_cnt_val;
        wr_sync_cnt = sync[ch];
      end else if (sub == mtmc_pkg::GEN_A_SUB) begin
        next_gen_a[ch] = merge16(general_register_a[ch], avs_writedata_i, avs_byteenable_i);
      end else if (sub == mtmc_pkg::GEN_B_SUB) begin
        next_gen_b[ch] = merge16(general_register_b[ch], avs_writedata_i, avs_byteenable_i);
      end
    end
    // preset of a synchronized counter loads the whole group
    for (int c = 0; c < N; c++) begin
      if (wr_sync_cnt && sync[c]) begin
        next_count[c] = wr_cnt_val;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start <= mtmc_pkg::START_RST;
      sync <= mtmc_pkg::SYNC_RST;
      phase <= mtmc_pkg::PHASE_RST;
      combo <= mtmc_pkg::MTMC_COMBO_NORM0;
      for (int c = 0; c < N; c++) begin
        ctrl[c] <= mtmc_pkg::CTRL_RST;
        timer_count_value[c] <= mtmc_pkg::COUNT_RST;
        general_register_a[c] <= mtmc_pkg::GR_RST;
        general_register_b[c] <= mtmc_pkg::GR_RST;
      end
      tri_down <= 1'b0;
      div <= 3'h0;
      a_sync <= 2'h0;
      b_sync <= 2'h0;
      a_old <= 1'b0;
      b_old <= 1'b0;
      wait_q <= 1'b1;
      rdata <= 32'h0;
      pwm <= 2'h0;
    end else begin
      start <= next_start;
      sync <= next_sync;
      phase <= next_phase;
      combo <= next_combo;
      ctrl <= next_ctrl;
      timer_count_value <= next_count;
      general_register_a <= next_gen_a;
      general_register_b <= next_gen_b;
      tri_down <= next_tri_down;
      div <= next_div;
      a_sync <= next_a_sync;
      b_sync <= next_b_sync;
      a_old <= next_a_old;
      b_old <= next_b_old;
      wait_q <= next_wait;
      rdata <= next_rdata;
      pwm <= next_pwm;
    end
  end

  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = wait_q;
  assign pwm_o = pwm;
endmodule : mtmc_timer
`default_nettype wire

/* File: tb/mtmc_timer_chk.sv */
// Checker: bus handshake, read data and PWM pair of the timer block.
// Assumes a bind to the top module; sees only its ports.
`default_nettype none
module mtmc_timer_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register bus
  input wire logic [mtmc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // PWM pair
  input wire logic [1:0] pwm_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] combo;
  logic rd_done;
  assign rd_done = avs_read_i && !avs_waitrequest_o;
  // Mode copy, only taken when the write really completes
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      combo <= 2'h0;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == mtmc_pkg::MODE_OFS) begin
      combo <= avs_writedata_i[5:4];
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_wait_one: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  a_upper_zero: assert property (rd_done |-> avs_readdata_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  a_ctrl_fixed: assert property (
    rd_done && avs_address_i[3:0] == mtmc_pkg::CTRL_SUB
    && avs_address_i[7:4] inside {[4'h1:4'h5]} |-> avs_readdata_o[7])
    else $error("control bit 7 not reading one");
  a_unmapped_zero: assert property (
    rd_done && avs_address_i == 8'h0C |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_pwm_off: assert property (
    (!combo[1]) [*3] |-> pwm_o == 2'h0)
    else $error("PWM active in independent mode");
  a_pwm_pair: assert property (
    combo[1] [*3] |-> pwm_o == 2'h1 || pwm_o == 2'h2)
    else $error("PWM pair not complementary");
endmodule // mtmc_timer_chk
bind mtmc_timer mtmc_timer_chk u_mtmc_timer_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pwm_o(pwm_o));
`default_nettype wire

/* File: tb/mtmc_timer_bench.sv */
// Bench for the timer block: registers, clock sources, clear, sync and modes.
// Assumes the checker file is compiled alongside and binds itself.
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module mtmc_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic ext_a = 1'b0;
  logic ext_b = 1'b0;
  logic [1:0] pwm_o;
  logic [31:0] exp_q[$];
  logic [31:0] mon_exp;
  logic [7:0] seed = 8'h57;
  int err_total = 0;
  int samples_checked = 0;
  // Control byte and count after a 64-cycle run of channel 1
  logic [7:0] cfg [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h14, 8'h0D, 8'h20, 8'h40};
  logic [31:0] cnt [12] = '{64, 32, 16, 8, 5, 5, 0, 0, 10, 5, 4, 1};
  logic [31:0] c3 [4] = '{64, 64, 16, 1};
  logic [31:0] c4 [4] = '{0, 0, 16, 1};
  mtmc_timer u_mtmc_timer (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .external_clock_input_a_i(ext_a), .external_clock_input_b_i(ext_b), .pwm_o(pwm_o));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // Stop write lands 64 cycles after start, so each divider sees whole periods
  task automatic span(input logic [4:0] st, input logic q);
    bus(mtmc_pkg::START_OFS, 1'b1, {27'h0, st});
    repeat (5) begin
      ext_a <= 1'b1;
      ext_b <= !q;
      repeat (3) @(posedge sys_clk_i);
      ext_b <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      ext_a <= 1'b0;
      ext_b <= q;
      repeat (3) @(posedge sys_clk_i);
      ext_b <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    bus(mtmc_pkg::START_OFS, 1'b1, 32'h0);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    if (avs_read_i && !avs_waitrequest_o) begin
      mon_exp = exp_q.pop_front();
      `CHK(avs_readdata_o, mon_exp)
    end
  end
  initial begin
    repeat (10000) @(posedge sys_clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    logic [7:0] a;
    repeat (12) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    rd(mtmc_pkg::START_OFS, 32'h0);
    rd(mtmc_pkg::SYNC_OFS, 32'h0);
    rd(mtmc_pkg::MODE_OFS, 32'h0);
    bus(8'h0C, 1'b1, 32'hFF);
    rd(8'h0C, 32'h0);
    for (int c = 0; c < 5; c++) begin
      a = 8'h10 + 8'(c << 4);
      rd(a, 32'h80);
      rd(a + 8'h4, 32'h0);
      rd(a + 8'h8, 32'hFFFF);
      rd(a + 8'hC, 32'hFFFF);
      seed = lfsr(seed);
      bus(a, 1'b1, {24'h0, seed});
      rd(a, {24'h0, 1'b1, seed[6:0]});
      bus(a, 1'b1, 32'h0);
    end
    $display("test reset and access done");
    bus(8'h28, 1'b1, 32'd9);
    bus(8'h2C, 1'b1, 32'd6);
    for (int i = 0; i < 12; i++) begin
      bus(8'h20, 1'b1, {24'h0, cfg[i]});
      bus(8'h24, 1'b1, 32'h0);
      span(5'h02, 1'b0);
      rd(8'h24, cnt[i]);
    end
    $display("test clock and clear sources done");
    bus(mtmc_pkg::SYNC_OFS, 1'b1, 32'h3);
    bus(8'h10, 1'b1, 32'h20);
    bus(8'h18, 1'b1, 32'd4);
    bus(8'h20, 1'b1, 32'h60);
    bus(8'h14, 1'b1, 32'h100);
    rd(8'h24, 32'h100);
    bus(8'h14, 1'b1, 32'h0);
    span(5'h03, 1'b0);
    rd(8'h14, 32'd4);
    rd(8'h24, 32'd4);
    bus(mtmc_pkg::SYNC_OFS, 1'b1, 32'h0);
    $display("test synchronized channels done");
    for (int p = 0; p < 2; p++) begin
      bus(mtmc_pkg::MODE_OFS, 1'b1, 32'(p) << 2);
      bus(8'h34, 1'b1, 32'h0);
      span(5'h04, 1'b1);
      rd(8'h34, p ? 32'd20 : 32'd64);
    end
    $display("test phase counting done");
    bus(8'h48, 1'b1, 32'd20);
    for (int m = 0; m < 4; m++) begin
      bus(mtmc_pkg::MODE_OFS, 1'b1, 32'(m) << 4);
      bus(8'h44, 1'b1, 32'h0);
      bus(8'h54, 1'b1, 32'h0);
      span(5'h08, 1'b0);
      `CHK(pwm_o, m[1] ? 2'h1 : 2'h0)
      rd(8'h44, c3[m]);
      rd(8'h54, c4[m]);
    end
    $display("test combination modes done");
    @(posedge sys_clk_i);
    end_sim();
  end
endmodule // mtmc_timer_bench
`default_nettype wire
